// file: core/interval_timer.sv
module interval_timer
	import lin_host_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic load_i,
	input wire logic [TMR_W-1:0] value_i,
	output logic busy_o
);
	logic [TMR_W-1:0] count_ff;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_ff <= '0;
		end else if (load_i) begin
			count_ff <= value_i;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign busy_o = (count_ff != '0);
endmodule

// file: core/lin_sbc_host.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
module lin_sbc_host
	import lin_host_pkg::*;
#(
	parameter logic [TMR_W-1:0] RESET_HOLD_CYC = RESET_HOLD_CYC_DEF,
	parameter logic [TMR_W-1:0] DOM_CYC = DOM_CYC_DEF
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic en_o,
	input wire logic txd_i,
	output logic txd_o,
	output logic txd_oe_o,
	input wire logic rxd_i,
	input wire logic reset_out_n_i,
	input wire logic local_wake_indicator_i,
	output logic low_side_a_ctrl_o,
	output logic low_side_b_ctrl_o,
	output logic high_side_ctrl_o
);
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == CTRL_OFS) || (a == CMD_OFS) || (a == STATUS_OFS);
	endfunction

	host_state_t state_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_held_ff, w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0] wbyte_ff;
	logic wbyte_en_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [3:0] ctrl_ff;
	logic en_ff, txd_ff, txd_oe_ff;
	logic ls_a_ff, ls_b_ff, hs_ff;
	logic [1:0] src_ff;
	logic src_vld_ff;
	logic boot_loaded_ff;
	logic [TMR_W-1:0] dom_cnt_ff;
	logic dom_to_ff;
	logic wr_do, cmd_wr, seq_load, seq_busy;
	logic [TMR_W-1:0] seq_val;
	logic rst_a, rst_b, rst_hs, hold_a, hold_b, hold_hs;
	logic [1:0] cmd;
	logic [31:0] status;
	mode_t mode;

	assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
	assign cmd_wr = wr_do && (awaddr_ff == CMD_OFS) && wbyte_en_ff;
	assign cmd = cmd_wr ? wbyte_ff[1:0] : CMD_NONE;
	assign rst_a = cmd_wr && wbyte_ff[CMD_RST_LS_A_BIT];
	assign rst_b = cmd_wr && wbyte_ff[CMD_RST_LS_B_BIT];
	assign rst_hs = cmd_wr && wbyte_ff[CMD_RST_HS_BIT];

	// Write channel: address and data may arrive in either order
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wbyte_ff <= 8'h00;
			wbyte_en_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			if (awvalid_i && awready_ff) begin
				awaddr_ff <= awaddr_i;
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (wvalid_i && wready_ff) begin
				wbyte_ff <= wdata_i[7:0];
				wbyte_en_ff <= wstrb_i[0];
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (wr_do) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_ff && bready_i) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_do && wbyte_en_ff && awaddr_ff == CTRL_OFS) begin
			ctrl_ff <= wbyte_ff[3:0];
		end
	end

	always_comb begin
		case (state_ff)
			ST_NORMAL: mode = MODE_NORMAL;
			ST_SILENT: mode = MODE_SILENT;
			ST_SLEEP: mode = MODE_SLEEP;
			default: mode = MODE_FAILSAFE;
		endcase
	end

	assign status = {22'h0, dom_to_ff, local_wake_indicator_i, reset_out_n_i,
		rxd_i, src_vld_ff, src_ff, seq_busy, mode};

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (arvalid_i && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= reg_hit(araddr_i) ? RESP_OKAY : RESP_SLVERR;
			if (araddr_i == CTRL_OFS) begin
				rdata_ff <= {28'h0, ctrl_ff};
			end else if (araddr_i == STATUS_OFS) begin
				rdata_ff <= status;
			end else begin
				rdata_ff <= 32'h0000_0000;
			end
		end else if (rvalid_ff && rready_i) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// Boot wait covers the device reset time; mode selects hold the window
	always_comb begin
		seq_load = 1'b0;
		seq_val = ARM_CYC;
		if (state_ff == ST_BOOT && !boot_loaded_ff) begin
			seq_load = 1'b1;
			seq_val = RESET_HOLD_CYC;
		end else if (!seq_busy && (cmd == CMD_SILENT || cmd == CMD_SLEEP)) begin
			seq_load = 1'b1;
		end
	end

	interval_timer u_seq_tmr (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.load_i(seq_load),
		.value_i(seq_val),
		.busy_o(seq_busy)
	);

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_loaded_ff <= 1'b0;
		end else if (state_ff == ST_BOOT) begin
			boot_loaded_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_BOOT;
			en_ff <= 1'b0;
			txd_ff <= 1'b1;
			txd_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_BOOT: begin
					if (boot_loaded_ff && !seq_busy) begin
						state_ff <= ST_FAILSAFE;
					end
				end
				ST_FAILSAFE: begin
					txd_oe_ff <= 1'b0;
					if (cmd == CMD_NORMAL && reset_out_n_i) begin
						en_ff <= 1'b1;
						txd_ff <= 1'b1;
						txd_oe_ff <= 1'b1;
						state_ff <= ST_NORMAL;
					end else if (cmd == CMD_SILENT && en_ff && !seq_busy) begin
						en_ff <= 1'b0;
						txd_ff <= 1'b1;
						txd_oe_ff <= 1'b1;
						state_ff <= ST_SILENT_SEL;
					end else if (cmd == CMD_SLEEP && en_ff && !seq_busy) begin
						en_ff <= 1'b0;
						txd_ff <= 1'b0;
						txd_oe_ff <= 1'b1;
						state_ff <= ST_SLEEP_SEL;
					end
				end
				ST_NORMAL: begin
					txd_ff <= ctrl_ff[CTRL_TX_BIT];
					if (!reset_out_n_i) begin
						state_ff <= ST_FAILSAFE;
					end else if (cmd == CMD_SILENT && !seq_busy) begin
						en_ff <= 1'b0;
						txd_ff <= 1'b1;
						state_ff <= ST_SILENT_SEL;
					end else if (cmd == CMD_SLEEP && !seq_busy) begin
						// Both edges in one cycle, no skew at all
						en_ff <= 1'b0;
						txd_ff <= 1'b0;
						state_ff <= ST_SLEEP_SEL;
					end
				end
				ST_SILENT_SEL: begin
					if (!seq_busy) begin
						txd_oe_ff <= 1'b0;
						state_ff <= ST_SILENT;
					end
				end
				ST_SLEEP_SEL: begin
					if (!seq_busy) begin
						txd_oe_ff <= 1'b0;
						state_ff <= ST_SLEEP;
					end
				end
				ST_SILENT: begin
					if (!reset_out_n_i || !txd_i) begin
						state_ff <= ST_FAILSAFE;
					end else if (cmd == CMD_NORMAL) begin
						en_ff <= 1'b1;
						txd_ff <= 1'b1;
						txd_oe_ff <= 1'b1;
						state_ff <= ST_NORMAL;
					end
				end
				ST_SLEEP: begin
					// Regulator back and reset released means a wake happened
					if (reset_out_n_i) begin
						state_ff <= ST_FAILSAFE;
					end else if (cmd == CMD_NORMAL) begin
						en_ff <= 1'b1;
						state_ff <= ST_FAILSAFE;
					end
				end
				default: begin
					state_ff <= ST_FAILSAFE;
				end
			endcase
		end
	end

	// Source code is only valid once the device drives both pins
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			src_ff <= 2'b00;
			src_vld_ff <= 1'b0;
		end else if (state_ff == ST_NORMAL) begin
			src_vld_ff <= 1'b0;
		end else if (state_ff == ST_FAILSAFE && reset_out_n_i && !txd_oe_ff) begin
			src_ff <= {txd_i, rxd_i};
			src_vld_ff <= 1'b1;
		end
	end

	// Dominant timeout mirror; clears once transmit is high again
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dom_cnt_ff <= '0;
			dom_to_ff <= 1'b0;
		end else if (state_ff != ST_NORMAL || txd_ff) begin
			dom_cnt_ff <= '0;
			dom_to_ff <= 1'b0;
		end else if (dom_cnt_ff >= DOM_CYC) begin
			dom_to_ff <= 1'b1;
		end else begin
			dom_cnt_ff <= dom_cnt_ff + 1'b1;
		end
	end

	// Restart pulls the control low long enough to clear the device latch
	interval_timer u_ls_a_tmr (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.load_i(rst_a),
		.value_i(ARM_CYC),
		.busy_o(hold_a)
	);

	interval_timer u_ls_b_tmr (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.load_i(rst_b),
		.value_i(ARM_CYC),
		.busy_o(hold_b)
	);

	interval_timer u_hs_tmr (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.load_i(rst_hs),
		.value_i(ARM_CYC),
		.busy_o(hold_hs)
	);

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ls_a_ff <= 1'b0;
			ls_b_ff <= 1'b0;
		end else begin
			// Held high as a level, so the arm pulse easily exceeds 10us
			ls_a_ff <= state_ff == ST_NORMAL && ctrl_ff[CTRL_LS_A_BIT]
				&& !hold_a && !rst_a;
			ls_b_ff <= state_ff == ST_NORMAL && ctrl_ff[CTRL_LS_B_BIT]
				&& !hold_b && !rst_b;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hs_ff <= 1'b0;
		end else begin
			hs_ff <= ctrl_ff[CTRL_HS_BIT] && state_ff != ST_SLEEP
				&& state_ff != ST_SLEEP_SEL
				&& !hold_hs && !rst_hs;
		end
	end

	assign awready_o = awready_ff;
	assign wready_o = wready_ff;
	assign bvalid_o = bvalid_ff;
	assign bresp_o = bresp_ff;
	assign arready_o = arready_ff;
	assign rvalid_o = rvalid_ff;
	assign rdata_o = rdata_ff;
	assign rresp_o = rresp_ff;
	assign en_o = en_ff;
	assign txd_o = txd_ff;
	assign txd_oe_o = txd_oe_ff;
	assign low_side_a_ctrl_o = ls_a_ff;
	assign low_side_b_ctrl_o = ls_b_ff;
	assign high_side_ctrl_o = hs_ff;
endmodule

// file: inc/lin_host_pkg.sv
// Function
// - Low-side input low at normal entry: off until high over 10us.
// - Enable falling with transmit high selects silent; hold it high.
// - Enable falling with transmit low selects sleep; hold it low.
// - Enable may fall up to 3.2us before transmit; together preferred.
package lin_host_pkg;
	localparam int CLK_MHZ = 20;
	localparam int TMR_W = 19;
	localparam int ADDR_W = 4;
	localparam int ARM_TIME_NS = 10000;
	localparam int RESET_HOLD_MS = 4;
	localparam int DOM_TIME_MS = 20;
	// Strictly longer than the figure, so one cycle is added
	localparam logic [TMR_W-1:0] ARM_CYC =
		TMR_W'((ARM_TIME_NS * CLK_MHZ + 999) / 1000 + 1);
	localparam logic [TMR_W-1:0] RESET_HOLD_CYC_DEF =
		TMR_W'(RESET_HOLD_MS * CLK_MHZ * 1000);
	localparam logic [TMR_W-1:0] DOM_CYC_DEF =
		TMR_W'(DOM_TIME_MS * CLK_MHZ * 1000);

	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] CMD_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;

	localparam int CTRL_LS_A_BIT = 0;
	localparam int CTRL_LS_B_BIT = 1;
	localparam int CTRL_HS_BIT = 2;
	localparam int CTRL_TX_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h8;

	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_NORMAL = 2'h1;
	localparam logic [1:0] CMD_SILENT = 2'h2;
	localparam logic [1:0] CMD_SLEEP = 2'h3;
	localparam int CMD_RST_LS_A_BIT = 4;
	localparam int CMD_RST_LS_B_BIT = 5;
	localparam int CMD_RST_HS_BIT = 6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_BOOT = 3'b000,
		ST_FAILSAFE = 3'b001,
		ST_NORMAL = 3'b010,
		ST_SILENT_SEL = 3'b011,
		ST_SILENT = 3'b100,
		ST_SLEEP_SEL = 3'b101,
		ST_SLEEP = 3'b110
	} host_state_t;

	typedef enum logic [1:0] {
		MODE_FAILSAFE = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_SILENT = 2'b10,
		MODE_SLEEP = 2'b11
	} mode_t;
endpackage

// file: verif/lin_host_props.sv
module lin_host_props
	import lin_host_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic bvalid_o,
	input wire logic bready_i,
	input wire logic rvalid_o,
	input wire logic rready_i,
	input wire logic en_o,
	input wire logic txd_o,
	input wire logic txd_oe_o,
	input wire logic reset_out_n_i,
	input wire logic low_side_a_ctrl_o,
	input wire logic low_side_b_ctrl_o,
	input wire logic high_side_ctrl_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence sel_hold;
		(txd_oe_o && $stable(txd_o)) [*8];
	endsequence
	sequence oe_drop;
		##[199:203] $fell(txd_oe_o);
	endsequence
	AST_SEL_HOLD: assert property (
		$fell(en_o) |-> ##1 sel_hold) else $error("txd not held in window");
	AST_SEL_LEN: assert property (
		$fell(en_o) |-> oe_drop) else $error("select window length wrong");
	AST_LS_EN: assert property (
		!en_o && !$past(en_o) |-> !low_side_a_ctrl_o && !low_side_b_ctrl_o)
		else $error("low side on without enable");
	AST_LS_UV: assert property (
		$fell(reset_out_n_i) |-> ##[1:4]
		!low_side_a_ctrl_o && !low_side_b_ctrl_o)
		else $error("low side kept on after reset low");
	AST_B_DONE: assert property (
		bvalid_o && bready_i |=> !bvalid_o) else $error("bvalid stuck");
	AST_R_DONE: assert property (
		rvalid_o && rready_i |=> !rvalid_o) else $error("rvalid stuck");
	AST_NORM: assert property (
		$rose(en_o) |-> txd_oe_o && txd_o)
		else $error("normal entry not recessive");
	AST_HS_SLEEP: assert property (
		$fell(txd_oe_o) && !txd_o && !en_o |=> !high_side_ctrl_o [*4])
		else $error("high side on in sleep");
endmodule

bind lin_sbc_host lin_host_props lin_host_props_i (.mclk_i, .reset_n_i,
	.bvalid_o, .bready_i, .rvalid_o, .rready_i, .en_o, .txd_o, .txd_oe_o,
	.reset_out_n_i, .low_side_a_ctrl_o, .low_side_b_ctrl_o, .high_side_ctrl_o);

// file: verif/sbc_device_model.sv
module sbc_device_model
	import lin_host_pkg::*;
#(
	parameter int HOLD = 30
) (
	input wire logic clk_i,
	input wire logic pwr_n_i,
	input wire logic en_i,
	input wire logic txd_i,
	input wire logic ls_a_i,
	input wire logic hs_i,
	input wire logic uv_i,
	input wire logic [1:0] wake_i,
	input wire logic fault_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rxd_o,
	output logic reset_out_n_o,
	output logic ls_a_o,
	output logic hs_o
);
	timeunit 1ns;
	timeprecision 1ns;
	mode_t mode;
	logic [1:0] src;
	logic en_d, trip, conduct, hs_trip, fault_d;
	int rcnt, arm;
	always_ff @(posedge clk_i or negedge pwr_n_i) begin
		if (!pwr_n_i) begin
			mode <= MODE_FAILSAFE;
			src <= 2'b11;
			rcnt <= HOLD;
			en_d <= 1'b0;
		end else begin
			en_d <= en_i;
			if (rcnt > 0)
				rcnt <= rcnt - 1;
			if (uv_i && mode inside {MODE_NORMAL, MODE_SILENT}) begin
				mode <= MODE_FAILSAFE;
				src <= 2'b10;
				rcnt <= HOLD;
			end else if (wake_i != 2'b00
				&& mode inside {MODE_SILENT, MODE_SLEEP}) begin
				// Bus wake stands for pre-wake and wake timer already run
				mode <= MODE_FAILSAFE;
				src <= {1'b0, wake_i[0]};
				if (mode == MODE_SLEEP)
					rcnt <= HOLD;
			end else if (en_d && !en_i
				&& (mode == MODE_NORMAL || src == 2'b10)) begin
				mode <= txd_i ? MODE_SILENT : MODE_SLEEP;
			end else if (!en_d && en_i && rcnt == 0
				&& mode == MODE_FAILSAFE) begin
				mode <= MODE_NORMAL;
				src <= 2'b11;
			end
		end
	end
	// Stricter than needed: any low level before arming restarts the count
	always_ff @(posedge clk_i) begin
		fault_d <= fault_i;
		conduct <= ls_a_o;
		if (mode != MODE_NORMAL)
			arm <= ls_a_i ? 300 : 0;
		else if (arm <= 200)
			arm <= ls_a_i ? arm + 1 : 0;
		// Blanked until the stage has conducted for a full cycle
		if (!ls_a_i)
			trip <= 1'b0;
		else if (fault_i && conduct)
			trip <= 1'b1;
		// A one-cycle fault glitch must not latch the high side
		if (!hs_i)
			hs_trip <= 1'b0;
		else if (fault_i && fault_d)
			hs_trip <= 1'b1;
	end
	assign ls_a_o = mode == MODE_NORMAL && en_i && ls_a_i && arm > 200
		&& !trip;
	assign hs_o = mode != MODE_SLEEP && hs_i
		&& !hs_trip;
	assign txd_oe_o = mode != MODE_NORMAL;
	assign txd_o = mode == MODE_FAILSAFE ? src[1]
		: mode == MODE_SILENT;
	assign rxd_o = mode == MODE_FAILSAFE ? src[0]
		: mode == MODE_NORMAL ? txd_i
		: mode == MODE_SILENT;
	assign reset_out_n_o = rcnt == 0
		&& mode != MODE_SLEEP;
endmodule

// file: verif/testbench.sv
module testbench
	import lin_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, uv = 0, fault = 0;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'h1;
	logic [31:0] wdata = 0, rdata, v;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, en, txd_h, txd_oe_h;
	logic txd_d, txd_oe_d, txd_w, rxd, rst_out_n, ls_a, ls_b, hs, ls_a_out;
	logic hs_out;
	logic [1:0] bresp, rresp, wake = 0;
	logic [65:0] rq[$], e;
	logic [1:0] wq[$];
	int n_mismatch = 0, n_tests = 0, seed = 32'haf9f;
	always #25 clk = ~clk;
	// Pull-up when nobody drives the line
	assign txd_w = txd_oe_h ? txd_h : txd_oe_d ? txd_d : 1'b1;
	lin_sbc_host #(.RESET_HOLD_CYC(TMR_W'(20)), .DOM_CYC(TMR_W'(50)))
	lin_sbc_host_i (.mclk_i(clk), .reset_n_i(rst_n), .awaddr_i(awaddr),
		.awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
		.wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
		.bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
		.arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
		.rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .en_o(en),
		.txd_i(txd_w), .txd_o(txd_h), .txd_oe_o(txd_oe_h), .rxd_i(rxd),
		.reset_out_n_i(rst_out_n), .local_wake_indicator_i(wake[0]),
		.low_side_a_ctrl_o(ls_a), .low_side_b_ctrl_o(ls_b),
		.high_side_ctrl_o(hs));
	sbc_device_model sbc_device_model_i (.clk_i(clk), .pwr_n_i(rst_n),
		.en_i(en), .txd_i(txd_w), .ls_a_i(ls_a), .hs_i(hs), .uv_i(uv),
		.wake_i(wake), .fault_i(fault), .txd_o(txd_d), .txd_oe_o(txd_oe_d),
		.rxd_o(rxd), .reset_out_n_o(rst_out_n), .ls_a_o(ls_a_out),
		.hs_o(hs_out));
	task automatic cmp(input logic [31:0] got, exp, msk);
		n_tests++;
		if ((got & msk) !== (exp & msk)) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic got, exp);
		cmp({31'h0, got}, {31'h0, exp}, 32'h1);
	endtask
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready) begin
			e = rq.pop_front();
			cmp(rdata, e[31:0], e[63:32]);
			cmp(32'(rresp), 32'(e[65:64]), 32'h3);
		end
		if (bvalid === 1'b1 && bready)
			cmp(32'(bresp), 32'(wq.pop_front()), 32'h3);
	end
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		wq.push_back(r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				do @(posedge clk); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge clk); while (!wready);
				wvalid <= 1'b0;
			end
		join
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x, m);
		rq.push_back({((a inside {CTRL_OFS, CMD_OFS, STATUS_OFS}) ?
			RESP_OKAY : RESP_SLVERR), m, x});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic pulse_wait(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		pulse_wait(20000);
		n_mismatch++;
		summarize();
	end
	initial begin
		pulse_wait(4);
		rst_n <= 1'b1;
		rd(CTRL_OFS, 32'(CTRL_RESET), 32'hf);
		rd(STATUS_OFS, 32'h0, 32'h83);
		wr(4'hc, 32'h1, RESP_SLVERR);
		rd(4'hc, 32'h0, '1);
		rd(CMD_OFS, 32'h0, '1);
		// Byte lane 0 disabled: the write must leave CTRL untouched
		wstrb <= 4'h0;
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wstrb <= 4'h1;
		rd(CTRL_OFS, 32'(CTRL_RESET), 32'hf);
		pulse_wait(40);
		rd(STATUS_OFS, 32'h80, 32'h83);
		wr(CTRL_OFS, 32'hb, RESP_OKAY);
		wr(CMD_OFS, 32'(CMD_NORMAL), RESP_OKAY);
		pulse_wait(4);
		rd(STATUS_OFS, 32'h1, 32'h23);
		pulse_wait(210);
		pin(ls_a_out, 1'b1);
		repeat (4) begin
			v = ($random(seed) & 32'h7) | 32'h8;
			wr(CTRL_OFS, v, RESP_OKAY);
			rd(CTRL_OFS, v, 32'hf);
			cmp({29'h0, hs, ls_b, ls_a}, v, 32'h7);
		end
		wr(CTRL_OFS, 32'hf, RESP_OKAY);
		fault <= 1'b1;
		@(posedge clk) fault <= 1'b0;
		@(posedge clk);
		pin(ls_a_out, 1'b0);
		pin(hs_out, 1'b1);
		wr(CMD_OFS, 32'h10, RESP_OKAY);
		pulse_wait(210);
		pin(ls_a_out, 1'b1);
		wr(CMD_OFS, 32'h60, RESP_OKAY);
		cmp({29'h0, hs, ls_b, ls_a}, 32'h1, 32'h7);
		pulse_wait(210);
		cmp({29'h0, hs, ls_b, ls_a}, 32'h7, 32'h7);
		wr(CTRL_OFS, 32'h7, RESP_OKAY);
		pulse_wait(60);
		rd(STATUS_OFS, 32'h201, 32'h203);
		wr(CMD_OFS, 32'(CMD_SLEEP), RESP_OKAY);
		pulse_wait(210);
		rd(STATUS_OFS, 32'h3, 32'h83);
		cmp({29'h0, hs, ls_b, ls_a}, 32'h0, 32'h7);
		wake <= 2'b10;
		@(posedge clk) wake <= 2'b00;
		pulse_wait(40);
		rd(STATUS_OFS, 32'h20, 32'h3b);
		wr(CMD_OFS, 32'(CMD_NORMAL), RESP_OKAY);
		pulse_wait(4);
		rd(STATUS_OFS, 32'h1, 32'h23);
		wr(CTRL_OFS, 32'hc, RESP_OKAY);
		wr(CMD_OFS, 32'(CMD_SILENT), RESP_OKAY);
		pulse_wait(210);
		rd(STATUS_OFS, 32'hc2, 32'hc3);
		cmp({29'h0, hs, ls_b, ls_a}, 32'h4, 32'h7);
		wake <= 2'b01;
		@(posedge clk) wake <= 2'b00;
		pulse_wait(10);
		rd(STATUS_OFS, 32'h28, 32'h3b);
		wr(CMD_OFS, 32'(CMD_NORMAL), RESP_OKAY);
		wr(CTRL_OFS, 32'hb, RESP_OKAY);
		uv <= 1'b1;
		@(posedge clk) uv <= 1'b0;
		pulse_wait(40);
		rd(STATUS_OFS, 32'h30, 32'h3b);
		cmp({29'h0, hs, ls_b, ls_a}, 32'h0, 32'h3);
		wr(CMD_OFS, 32'(CMD_SILENT), RESP_OKAY);
		pulse_wait(210);
		rd(STATUS_OFS, 32'h2, 32'h3);
		summarize();
	end
endmodule
